// ==== src/supply_monitor_regs.sv ====
// Notes on behaviour
// - Control A bit 4 picks sampling: 0 is 1 kHz, 1 is 125 Hz.
// - Sample-rate bit loads from the fuse at reset and is read-only.
// - Awake mode bits 3:2: off, on, sampled, on with wake held until ready.
// - Awake mode drives the monitor while running or idle; reset from fuse.
// - Dormant mode bits 1:0 rule standby and power-down; 3 reserved; from fuse.
// - Dormant mode accepts writes only after the guard unlock.
// - Control B bits 2:0 hold the fuse threshold, read-only, upper bits zero.
// - Margin bits 1:0 at 0x08: 5, 15 or 25 percent above threshold.
// - Edge bits 2:1 choose falling, rising or either crossing; 3 reserved.
// - Interrupt control bit 0 enables the warning interrupt; resets to zero.
// - Flag bit 0 at 0x0A sets on a trigger matching the chosen edge.
// - A trigger sets the flag only while the monitor runs or samples; a written one clears it in any mode.
// - State bit 0 at 0x0B reads 1 while the supply is below warning level.
// - The below state has meaning only while the monitor runs.
// - Interrupt stays high while enable and flag are both set.
// - Guarded write counts only within four cycles after the unlock key.
// - Deep sleep uses the dormant mode; waking returns to the awake mode.
`timescale 1ns/1ps

module supply_monitor_regs #(
    parameter int SAMPLE_CYCLES_FAST = supply_monitor_pkg::SAMPLE_CYCLES_FAST,
    parameter int SAMPLE_CYCLES_SLOW = supply_monitor_pkg::SAMPLE_CYCLES_SLOW
) (
    // Clock, reset and enable
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        clk_en,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // Fuse image, static pins
    input  wire logic        fuse_sample_rate,
    input  wire logic [1:0]  fuse_awake_mode,
    input  wire logic [1:0]  fuse_dormant_mode,
    input  wire logic [2:0]  fuse_threshold,
    // Guard unlock pulse and sleep request from same-clock logic
    input  wire logic        config_guard_unlock,
    input  wire logic        deep_sleep_req,
    // Analog side pins
    input  wire logic        warn_below_pin,
    input  wire logic        monitor_ready_pin,
    // Monitor control outputs
    output logic [1:0]       monitor_mode,
    output logic             sample_rate_sel,
    output logic [2:0]       threshold_sel,
    output logic [1:0]       warn_margin_sel,
    output logic             wake_hold,
    output logic             irq
);

    localparam int EXT_W = 10;

    // Register index from a byte address
    function automatic logic [7:0] reg_index(input logic [31:0] addr);
        reg_index = addr[9:2];
    endfunction : reg_index

    // True when a mode keeps the monitor running or sampling
    function automatic logic mode_is_on(input logic [1:0] mode);
        mode_is_on = (mode != supply_monitor_pkg::MODE_OFF);
    endfunction : mode_is_on

    // Synchronisers for every pin that arrives from outside the clock domain
    logic [EXT_W-1:0] ext_raw;
    logic [EXT_W-1:0] ext_meta;
    logic [EXT_W-1:0] ext_sync;

    assign ext_raw = {monitor_ready_pin, warn_below_pin, fuse_threshold,
                      fuse_dormant_mode, fuse_awake_mode, fuse_sample_rate};

    genvar gi;
    generate
        for (gi = 0; gi < EXT_W; gi++) begin : g_sync
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    ext_meta[gi] <= 1'b0;
                    ext_sync[gi] <= 1'b0;
                end else if (clk_en) begin
                    ext_meta[gi] <= ext_raw[gi];
                    ext_sync[gi] <= ext_meta[gi];
                end
            end
        end
    endgenerate

    logic       fuse_rate_s;
    logic [1:0] fuse_awake_s;
    logic [1:0] fuse_dormant_s;
    logic [2:0] fuse_threshold_s;
    logic       below_s;
    logic       ready_s;

    assign fuse_rate_s      = ext_sync[0];
    assign fuse_awake_s     = ext_sync[2:1];
    assign fuse_dormant_s   = ext_sync[4:3];
    assign fuse_threshold_s = ext_sync[7:5];
    assign below_s          = ext_sync[8];
    assign ready_s          = ext_sync[9];

    // Register state
    logic [1:0] awake_mode_q;
    logic [1:0] dormant_mode;
    logic [1:0] edge_sel;
    logic       irq_enable;
    logic       irq_flag;
    logic [1:0] fuse_count;
    logic       fuse_loaded;
    logic [2:0] guard_count;

    // Bus address phase capture
    logic       dp_write;
    logic [7:0] dp_index;
    logic       addr_valid;
    logic [7:0] ap_index;

    assign addr_valid = hsel && hready && htrans[1];
    assign ap_index   = reg_index(haddr);

    // Data phase write strobes
    logic wr_control_a;
    logic wr_margin;
    logic wr_irq_control;
    logic wr_irq_flags;
    logic guard_open;

    assign wr_control_a   = dp_write && (dp_index == supply_monitor_pkg::IDX_CONTROL_A);
    assign wr_margin      = dp_write && (dp_index == supply_monitor_pkg::IDX_MARGIN_CONTROL);
    assign wr_irq_control = dp_write && (dp_index == supply_monitor_pkg::IDX_IRQ_CONTROL);
    assign wr_irq_flags   = dp_write && (dp_index == supply_monitor_pkg::IDX_IRQ_FLAGS);
    assign guard_open     = (guard_count != 3'h0);

    // Fuse image is taken once the synchronisers have filled
    logic fuse_take;
    assign fuse_take = !fuse_loaded &&
                       (fuse_count == 2'(supply_monitor_pkg::FUSE_SETTLE_CYCLES - 1));

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fuse_count  <= 2'h0;
            fuse_loaded <= 1'b0;
        end else if (clk_en && !fuse_loaded) begin
            fuse_count  <= fuse_count + 2'h1;
            fuse_loaded <= fuse_take;
        end
    end

    // Fuse-loaded fields
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sample_rate_sel <= 1'b0;
            awake_mode_q    <= supply_monitor_pkg::MODE_OFF;
            threshold_sel   <= 3'h0;
        end else if (clk_en && fuse_take) begin
            sample_rate_sel <= fuse_rate_s;
            awake_mode_q    <= fuse_awake_s;
            threshold_sel   <= fuse_threshold_s;
        end
    end

    // Guard window opened by the unlock key
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            guard_count <= 3'h0;
        end else if (clk_en) begin
            if (config_guard_unlock) begin
                guard_count <= 3'(supply_monitor_pkg::GUARD_WINDOW_CYCLES);
            end else if (wr_control_a) begin
                guard_count <= 3'h0;
            end else if (guard_open) begin
                guard_count <= guard_count - 3'h1;
            end
        end
    end

    // Dormant mode: fuse at reset, guarded software write afterwards
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dormant_mode <= supply_monitor_pkg::MODE_OFF;
        end else if (clk_en) begin
            if (fuse_take) begin
                dormant_mode <= fuse_dormant_s;
            end else if (wr_control_a && guard_open) begin
                dormant_mode <= hwdata[supply_monitor_pkg::POS_DORMANT_MODE +: 2];
            end
        end
    end

    // Software registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            warn_margin_sel <= supply_monitor_pkg::RST_MARGIN;
            edge_sel        <= supply_monitor_pkg::RST_EDGE_SEL;
            irq_enable      <= supply_monitor_pkg::RST_IRQ_ENABLE;
        end else if (clk_en) begin
            if (wr_margin) begin
                warn_margin_sel <= hwdata[supply_monitor_pkg::POS_MARGIN +: 2];
            end
            if (wr_irq_control) begin
                edge_sel   <= hwdata[supply_monitor_pkg::POS_EDGE_SEL +: 2];
                irq_enable <= hwdata[supply_monitor_pkg::POS_IRQ_ENABLE];
            end
        end
    end

    // Power state follows the sleep controller
    supply_monitor_pkg::power_state_t pstate;
    supply_monitor_pkg::power_state_t next_pstate;
    logic                             hold_needed;

    assign hold_needed = (awake_mode_q == supply_monitor_pkg::MODE_ON_HOLD) && !ready_s;

    always_comb begin
        next_pstate = pstate;
        case (pstate)
            supply_monitor_pkg::PS_AWAKE: begin
                if (deep_sleep_req) begin
                    next_pstate = supply_monitor_pkg::PS_DORMANT;
                end
            end
            supply_monitor_pkg::PS_DORMANT: begin
                if (!deep_sleep_req) begin
                    next_pstate = supply_monitor_pkg::PS_WAKING;
                end
            end
            supply_monitor_pkg::PS_WAKING: begin
                if (deep_sleep_req) begin
                    next_pstate = supply_monitor_pkg::PS_DORMANT;
                end else if (!hold_needed) begin
                    next_pstate = supply_monitor_pkg::PS_AWAKE;
                end
            end
            default: next_pstate = supply_monitor_pkg::PS_AWAKE;
        endcase
    end

    // Mode in force for the present power state
    logic [1:0] next_mode;
    assign next_mode = (next_pstate == supply_monitor_pkg::PS_DORMANT)
                     ? ((dormant_mode == supply_monitor_pkg::MODE_ON_HOLD)
                        ? supply_monitor_pkg::MODE_OFF : dormant_mode)
                     : awake_mode_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pstate       <= supply_monitor_pkg::PS_AWAKE;
            monitor_mode <= supply_monitor_pkg::MODE_OFF;
            wake_hold    <= 1'b0;
        end else if (clk_en) begin
            pstate       <= next_pstate;
            monitor_mode <= next_mode;
            // Wake-up held off while waking; in awake mode MODE_ON_HOLD until the monitor reports ready
            wake_hold    <= (next_pstate == supply_monitor_pkg::PS_WAKING);
        end
    end

    // Crossing detection and sampling
    logic warn_below_state;
    logic trigger;

    warn_crossing_detect #(
        .SAMPLE_CYCLES_FAST (SAMPLE_CYCLES_FAST),
        .SAMPLE_CYCLES_SLOW (SAMPLE_CYCLES_SLOW)
    ) u_detect (
        .hclk             (hclk),
        .hresetn          (hresetn),
        .clk_en           (clk_en),
        .mode             (monitor_mode),
        .sample_rate_sel  (sample_rate_sel),
        .warn_edge_sel    (edge_sel),
        .below_now        (below_s),
        .warn_below_state (warn_below_state),
        .trigger          (trigger)
    );

    // Warning flag: trigger sets, a one written clears, set wins
    logic flag_clear;
    logic flag_set;
    logic next_irq_enable;

    // Request follows the enable in the same cycle that software changes it
    assign next_irq_enable = wr_irq_control ? hwdata[supply_monitor_pkg::POS_IRQ_ENABLE]
                                            : irq_enable;

    assign flag_clear = wr_irq_flags && hwdata[supply_monitor_pkg::POS_IRQ_FLAG];
    assign flag_set   = trigger && mode_is_on(monitor_mode);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_flag <= supply_monitor_pkg::RST_IRQ_FLAG;
            irq      <= 1'b0;
        end else if (clk_en) begin
            if (flag_set) begin
                irq_flag <= 1'b1;
            end else if (flag_clear) begin
                irq_flag <= 1'b0;
            end
            irq <= next_irq_enable && (flag_set || (irq_flag && !flag_clear));
        end
    end

    // Read data, selected during the address phase
    logic [7:0] rd_control_a;
    logic [7:0] rd_control_b;
    logic [7:0] rd_margin;
    logic [7:0] rd_irq_control;
    logic [7:0] rd_irq_flags;
    logic [7:0] rd_state;
    logic [7:0] rd_byte;

    assign rd_control_a   = {3'h0, sample_rate_sel, awake_mode_q, dormant_mode};
    assign rd_control_b   = {5'h00, threshold_sel};
    assign rd_margin      = {6'h00, warn_margin_sel};
    assign rd_irq_control = {5'h00, edge_sel, irq_enable};
    assign rd_irq_flags   = {7'h00, irq_flag};
    // Below state is only meaningful while the monitor runs
    assign rd_state       = {7'h00, warn_below_state};

    always_comb begin
        case (ap_index)
            supply_monitor_pkg::IDX_CONTROL_A:      rd_byte = rd_control_a;
            supply_monitor_pkg::IDX_CONTROL_B:      rd_byte = rd_control_b;
            supply_monitor_pkg::IDX_MARGIN_CONTROL: rd_byte = rd_margin;
            supply_monitor_pkg::IDX_IRQ_CONTROL:    rd_byte = rd_irq_control;
            supply_monitor_pkg::IDX_IRQ_FLAGS:      rd_byte = rd_irq_flags;
            supply_monitor_pkg::IDX_WARN_STATE:     rd_byte = rd_state;
            default:                                rd_byte = 8'h00;
        endcase
    end

    // AHB-Lite slave: zero wait states, always OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_write  <= 1'b0;
            dp_index  <= 8'h00;
            hrdata    <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else if (clk_en) begin
            dp_write <= addr_valid && hwrite && (hsize == 3'h2);
            dp_index <= ap_index;
            if (addr_valid && !hwrite) begin
                hrdata <= {24'h000000, rd_byte};
            end
        end
    end

endmodule : supply_monitor_regs

// ==== src/supply_monitor_pkg.sv ====
package supply_monitor_pkg;

    // Register indices; the byte address on the bus is four times the index
    localparam logic [7:0] IDX_CONTROL_A      = 8'h00;
    localparam logic [7:0] IDX_CONTROL_B      = 8'h01;
    localparam logic [7:0] IDX_MARGIN_CONTROL = 8'h08;
    localparam logic [7:0] IDX_IRQ_CONTROL    = 8'h09;
    localparam logic [7:0] IDX_IRQ_FLAGS      = 8'h0a;
    localparam logic [7:0] IDX_WARN_STATE     = 8'h0b;

    // Field positions
    localparam int POS_DORMANT_MODE = 0;
    localparam int POS_AWAKE_MODE   = 2;
    localparam int POS_SAMPLE_RATE  = 4;
    localparam int POS_THRESHOLD    = 0;
    localparam int POS_MARGIN       = 0;
    localparam int POS_IRQ_ENABLE   = 0;
    localparam int POS_EDGE_SEL     = 1;
    localparam int POS_IRQ_FLAG     = 0;
    localparam int POS_BELOW_STATE  = 0;

    // Reset values of the software registers
    localparam logic [1:0] RST_MARGIN     = 2'h0;
    localparam logic [1:0] RST_EDGE_SEL   = 2'h0;
    localparam logic       RST_IRQ_ENABLE = 1'b0;
    localparam logic       RST_IRQ_FLAG   = 1'b0;

    // Monitor modes
    localparam logic [1:0] MODE_OFF       = 2'h0;
    localparam logic [1:0] MODE_ON        = 2'h1;
    localparam logic [1:0] MODE_SAMPLED   = 2'h2;
    localparam logic [1:0] MODE_ON_HOLD   = 2'h3;

    // Crossing selections
    localparam logic [1:0] EDGE_FALLING   = 2'h0;
    localparam logic [1:0] EDGE_RISING    = 2'h1;
    localparam logic [1:0] EDGE_EITHER    = 2'h2;

    // Timing
    localparam int CLK_PERIOD_NS         = 10;
    localparam int SAMPLE_PERIOD_FAST_NS = 1_000_000;
    localparam int SAMPLE_PERIOD_SLOW_NS = 8_000_000;
    localparam int SAMPLE_CYCLES_FAST    = SAMPLE_PERIOD_FAST_NS / CLK_PERIOD_NS;
    localparam int SAMPLE_CYCLES_SLOW    = SAMPLE_PERIOD_SLOW_NS / CLK_PERIOD_NS;
    localparam int GUARD_WINDOW_INSTR    = 4;
    localparam int GUARD_WINDOW_CYCLES   = GUARD_WINDOW_INSTR;
    localparam int FUSE_SETTLE_CYCLES    = 3;

    // Monitor power state, one bit changes along awake -> dormant -> waking, both bits on waking -> awake
    typedef enum logic [1:0] {
        PS_AWAKE   = 2'b00,
        PS_DORMANT = 2'b01,
        PS_WAKING  = 2'b11
    } power_state_t;

endpackage : supply_monitor_pkg

// ==== src/warn_crossing_detect.sv ====
`timescale 1ns/1ps

module warn_crossing_detect #(
    parameter int SAMPLE_CYCLES_FAST = supply_monitor_pkg::SAMPLE_CYCLES_FAST,
    parameter int SAMPLE_CYCLES_SLOW = supply_monitor_pkg::SAMPLE_CYCLES_SLOW
) (
    // Clock and reset
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic       clk_en,
    // Settings
    input  wire logic [1:0] mode,
    input  wire logic       sample_rate_sel,
    input  wire logic [1:0] warn_edge_sel,
    // Comparator level, already synchronised
    input  wire logic       below_now,
    // Results
    output logic            warn_below_state,
    output logic            trigger
);

    logic [19:0] sample_count;
    logic [19:0] sample_limit;
    logic        sample_tick;
    logic        running;
    logic        sampled;
    logic        look;
    logic        fell;
    logic        rose;

    assign sample_limit = sample_rate_sel ? 20'(SAMPLE_CYCLES_SLOW - 1)
                                          : 20'(SAMPLE_CYCLES_FAST - 1);
    assign sample_tick  = (sample_count == sample_limit);
    assign sampled      = (mode == supply_monitor_pkg::MODE_SAMPLED);
    assign running      = (mode == supply_monitor_pkg::MODE_ON) ||
                          (mode == supply_monitor_pkg::MODE_ON_HOLD);
    assign look         = running || (sampled && sample_tick);
    assign fell         = below_now && !warn_below_state;
    assign rose         = !below_now && warn_below_state;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sample_count     <= 20'h00000;
            warn_below_state <= 1'b0;
            trigger          <= 1'b0;
        end else if (clk_en) begin
            sample_count <= (sample_tick || !sampled) ? 20'h00000 : sample_count + 20'h00001;
            if (look) begin
                warn_below_state <= below_now;
            end
            case (warn_edge_sel)
                supply_monitor_pkg::EDGE_FALLING: trigger <= look && fell;
                supply_monitor_pkg::EDGE_RISING:  trigger <= look && rose;
                supply_monitor_pkg::EDGE_EITHER:  trigger <= look && (fell || rose);
                default:                          trigger <= 1'b0;
            endcase
        end
    end

endmodule : warn_crossing_detect

// ==== bench/supply_monitor_regs_sva.sv ====
`timescale 1ns/1ps

module supply_monitor_regs_sva (
    // Clock and reset
    input wire logic        hclk,
    input wire logic        hresetn,
    // Bus
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hwdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    // Fuses and sleep
    input wire logic        fuse_sample_rate,
    input wire logic [1:0]  fuse_awake_mode,
    input wire logic [2:0]  fuse_threshold,
    input wire logic        deep_sleep_req,
    // Monitor outputs
    input wire logic [1:0]  monitor_mode,
    input wire logic        sample_rate_sel,
    input wire logic [2:0]  threshold_sel,
    input wire logic [1:0]  warn_margin_sel,
    input wire logic        irq
);
    logic [2:0] up;
    logic       dp_wr;
    logic [7:0] dp_idx;
    logic       ok;
    logic       clr_ev;

    // Fuse fields settle a few edges after release
    assign ok = (up == 3'h7);
    assign clr_ev = dp_wr && ((dp_idx == supply_monitor_pkg::IDX_IRQ_FLAGS && hwdata[0])
                    || (dp_idx == supply_monitor_pkg::IDX_IRQ_CONTROL && !hwdata[0]));

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            up     <= 3'h0;
            dp_wr  <= 1'b0;
            dp_idx <= 8'h00;
        end else begin
            up     <= ok ? up : up + 3'h1;
            dp_wr  <= hsel && hready && htrans[1] && hwrite;
            dp_idx <= haddr[9:2];
        end
    end

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_ready_high: assert property (hreadyout)
        else $error("hreadyout low");
    a_resp_okay: assert property (!hresp)
        else $error("error response");
    a_rdata_upper: assert property (hrdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    a_rate_fuse: assert property (ok |-> sample_rate_sel == fuse_sample_rate)
        else $error("sample rate differs from fuse");
    a_thresh_fuse: assert property (ok |-> threshold_sel == fuse_threshold)
        else $error("threshold differs from fuse");
    a_awake_mode: assert property (ok && !deep_sleep_req && !$past(deep_sleep_req)
        && !$past(deep_sleep_req, 2) |-> monitor_mode == fuse_awake_mode)
        else $error("awake mode not in force");
    a_dormant_no3: assert property (deep_sleep_req && $past(deep_sleep_req)
        && $past(deep_sleep_req, 2) |-> monitor_mode != 2'h3)
        else $error("reserved dormant mode in force");
    a_irq_fall: assert property ($fell(irq) |-> $past(clr_ev))
        else $error("irq dropped without clear");
    a_margin_wr: assert property (dp_wr && dp_idx == supply_monitor_pkg::IDX_MARGIN_CONTROL
        |-> ##2 warn_margin_sel == $past(hwdata[1:0], 2))
        else $error("margin output not updated");

endmodule : supply_monitor_regs_sva

bind supply_monitor_regs supply_monitor_regs_sva i_supply_monitor_regs_sva (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .fuse_sample_rate(fuse_sample_rate),
    .fuse_awake_mode(fuse_awake_mode), .fuse_threshold(fuse_threshold),
    .deep_sleep_req(deep_sleep_req), .monitor_mode(monitor_mode),
    .sample_rate_sel(sample_rate_sel), .threshold_sel(threshold_sel),
    .warn_margin_sel(warn_margin_sel), .irq(irq)
);

// ==== bench/tb_top.sv ====
`timescale 1ns/1ps

module tb_top;
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic [31:0] hrdata;
    logic        f_rate;
    logic [1:0]  f_dorm;
    logic [2:0]  f_thr;
    logic        unlock;
    logic        sleep;
    logic        pin;
    logic        ready;
    logic        hold;
    logic [1:0]  f_awake;
    logic [1:0]  monitor_mode;
    logic [1:0]  warn_margin_sel;
    logic        irq;
    logic [31:0] seed;
    logic [31:0] rd;
    logic [1:0]  dm;
    int          err_count;
    int          comparisons;

    supply_monitor_regs #(.SAMPLE_CYCLES_FAST(8), .SAMPLE_CYCLES_SLOW(16)) i_supply_monitor_regs (
        .hclk(hclk), .hresetn(hresetn), .clk_en(1'b1), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(), .hrdata(hrdata), .fuse_sample_rate(f_rate),
        .fuse_awake_mode(f_awake), .fuse_dormant_mode(f_dorm), .fuse_threshold(f_thr),
        .config_guard_unlock(unlock), .deep_sleep_req(sleep), .warn_below_pin(pin),
        .monitor_ready_pin(ready), .monitor_mode(monitor_mode), .sample_rate_sel(),
        .threshold_sel(), .warn_margin_sel(warn_margin_sel), .wake_hold(hold), .irq(irq)
    );

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    function automatic logic [31:0] ctl_a(input logic [1:0] d);
        return {27'h0, f_rate, f_awake, d};
    endfunction : ctl_a

    function automatic logic [31:0] exp_flag(input int e, input logic down);
        return (e == 2 || e == {31'h0, ~down}) ? 32'h1 : 32'h0;
    endfunction : exp_flag

    task automatic finish_test();
        $display("errors %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : finish_test

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        comparisons++;
        if (s !== e) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd,
                       output logic [31:0] r);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {22'h0, idx, 2'h0};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask : bus

    task automatic rchk(input logic [7:0] idx, input logic [31:0] e, input string n);
        logic [31:0] r;
        bus(1'b0, idx, 32'h0, r);
        chk(n, e, r);
    endtask : rchk

    // Guarded write to control A: unlock pulse, then the write inside the window
    task automatic gw(input logic [31:0] v);
        logic [31:0] r;
        @(posedge hclk);
        unlock <= 1'b1;
        @(posedge hclk);
        unlock <= 1'b0;
        bus(1'b1, 8'h00, v, r);
    endtask : gw

    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    initial begin
        repeat (20000) @(posedge hclk);
        err_count++;
        finish_test();
    end

    initial begin
        seed = 32'h0000ca99;
        {hresetn, hsel, haddr, htrans, hwrite, hwdata, unlock, sleep, pin, ready} = '0;
        rd = rnd();
        f_rate = rd[0];
        f_thr = rd[3:1];
        f_dorm = (rd[5:4] == 2'h3) ? 2'h2 : rd[5:4];
        f_awake = rd[6] ? 2'h3 : 2'h1;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (6) @(posedge hclk);
        rchk(8'h00, ctl_a(f_dorm), "control_a");
        rchk(8'h01, {29'h0, f_thr}, "control_b");
        for (int i = 8; i < 12; i++)
            rchk(i[7:0], 32'h0, "reset_value");
        bus(1'b1, 8'h00, 32'hff, rd);
        rchk(8'h00, ctl_a(f_dorm), "unguarded");
        bus(1'b1, 8'h01, rnd(), rd);
        rchk(8'h01, {29'h0, f_thr}, "control_b_ro");
        bus(1'b1, 8'h05, rnd(), rd);
        rchk(8'h05, 32'h0, "unmapped");
        for (int k = 0; k < 4; k++) begin
            dm = 2'(3 - k);
            rd = rnd();
            gw({rd[31:2], dm});
            rchk(8'h00, ctl_a(dm), "guarded");
            ready <= (k != 0);
            sleep <= 1'b1;
            repeat (4) @(posedge hclk);
            chk("dormant_mode", {30'h0, (dm == 2'h3) ? 2'h0 : dm}, {30'h0, monitor_mode});
            sleep <= 1'b0;
            repeat (4) @(posedge hclk);
            chk("awake_mode", {30'h0, f_awake}, {30'h0, monitor_mode});
            chk("wake_hold", {31'h0, (f_awake == 2'h3 && k == 0)}, {31'h0, hold});
            ready <= 1'b1;
        end
        // Dormant mode is now off: the flag must hold through a crossing in sleep
        bus(1'b1, 8'h09, 32'h1, rd);
        sleep <= 1'b1;
        repeat (4) @(posedge hclk);
        pin <= 1'b1;
        repeat (8) @(posedge hclk);
        rchk(8'h0a, 32'h0, "flag_hold");
        sleep <= 1'b0;
        repeat (8) @(posedge hclk);
        rchk(8'h0a, 32'h1, "flag_wake");
        bus(1'b1, 8'h0a, 32'h1, rd);
        pin <= 1'b0;
        repeat (8) @(posedge hclk);
        for (int i = 0; i < 3; i++) begin
            rd = rnd();
            bus(1'b1, 8'h08, {rd[31:2], i[1:0]}, rd);
            rchk(8'h08, i, "margin");
            chk("margin_out", i, {30'h0, warn_margin_sel});
        end
        for (int e = 0; e < 4; e++) begin
            rd = rnd();
            bus(1'b1, 8'h09, {rd[31:3], e[1:0], 1'b1}, rd);
            rchk(8'h09, {29'h0, e[1:0], 1'b1}, "irq_control");
            bus(1'b1, 8'h0a, 32'h1, rd);
            pin <= 1'b1;
            repeat (8) @(posedge hclk);
            bus(1'b1, 8'h0a, 32'h0, rd);
            rchk(8'h0a, exp_flag(e, 1'b1), "flag_down");
            chk("irq", exp_flag(e, 1'b1), {31'h0, irq});
            rchk(8'h0b, 32'h1, "below_state");
            bus(1'b1, 8'h0a, 32'h1, rd);
            rchk(8'h0a, 32'h0, "flag_clear");
            chk("irq_clear", 32'h0, {31'h0, irq});
            pin <= 1'b0;
            repeat (8) @(posedge hclk);
            rchk(8'h0a, exp_flag(e, 1'b0), "flag_up");
            rchk(8'h0b, 32'h0, "above_state");
        end
        finish_test();
    end

endmodule : tb_top
